//--- src/rcp_regs.vh
// Register map, field positions, reset values and timing counts of the reset/clock/power block.
`ifndef RCP_REGS_VH
`define RCP_REGS_VH
// Register byte addresses (word aligned).
`define RCP_ADDR_PMODE 4'h0
`define RCP_ADDR_CFG 4'h4
`define RCP_ADDR_STAT 4'h8
`define RCP_ADDR_PMC 4'hc
// Power-mode entry register fields.
`define RCP_HALT_BIT 0
`define RCP_IDLE_BIT 1
// Configuration register fields.
`define RCP_CSEL_LSB 0
`define RCP_CSEL_MSB 1
`define RCP_CFG_RESET 2'h0
// Clock source codes.
`define RCP_CSEL_INT 2'h0
`define RCP_CSEL_SQ 2'h1
`define RCP_CSEL_XTAL 2'h2
`define RCP_CSEL_RC 2'h3
// Timing: clock rate, delays in their own units, derived cycle counts.
`define RCP_CLK_KHZ 40000
`define RCP_STARTUP_US 1000
`define RCP_STARTUP_CYC ((`RCP_STARTUP_US * `RCP_CLK_KHZ + 999) / 1000)
`define RCP_T0_PERIOD 8192
`define RCP_OSC_DIV 20
`endif

//--- src/rcp_reset_clock_power.v
// Reset sequencer, clock source selection and HALT/IDLE power modes with an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "rcp_regs.vh"

module rcp_reset_clock_power #(
    parameter STARTUP_CYCLES = `RCP_STARTUP_CYC
) (
    // Clock and reset.
    input wire mclk,
    input wire rst,
    // Reset sources.
    input wire powerOnDetect,
    input wire brownoutDetect,
    input wire watchdogExpire,
    input wire resetPinN,
    input wire resetPinPresent,
    // Wake sources and clock pins.
    input wire multiInputWakeup,
    input wire clockInputPin,
    // AXI4-Lite slave.
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // System outputs.
    output reg coreResetQ,
    output reg ioResetQ,
    output reg instrClkEnQ,
    output reg oscRunQ,
    output reg detectorsEnQ,
    output reg timer0RunQ,
    output reg crystalOutQ,
    output reg crystalOutEnQ
);

    localparam ST_RESET = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_HALT = 2'h2;
    localparam ST_IDLE = 2'h3;

    // Counter end points, cut to the counter widths on purpose so no compare mixes widths.
    localparam [31:0] STARTUP_FULL = STARTUP_CYCLES;
    localparam [22:0] STARTUP_LAST = STARTUP_FULL[22:0] - 23'h1;
    localparam [31:0] OSC_DIV_FULL = `RCP_OSC_DIV;
    localparam [4:0] OSC_LAST = OSC_DIV_FULL[4:0] - 5'h1;

    reg [1:0] state_q;
    reg [22:0] startCnt_q;
    reg starting_q;
    reg [1:0] clockSel_q;
    reg haltReq_q;
    reg idleReq_q;
    reg pmcPending_q;
    reg [12:0] t0Cnt_q;
    reg [4:0] oscCnt_q;
    reg oscEn_q;
    reg oscHalf_q;
    reg [1:0] extDiv_q;
    reg ckiPrev_q;
    reg awHeld_q;
    reg wHeld_q;
    reg [3:0] awAddr_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;

    wire anyReset;
    wire ckiRise;
    wire t0Overflow;
    wire wrFire;
    wire [3:0] wrAddr;
    wire [31:0] wrData;
    wire wrLane0;

    // Every reset source is ORed; the pin is pulled up so it only counts when present and low.
    assign anyReset = rst | powerOnDetect | brownoutDetect | watchdogExpire
        | (resetPinPresent & ~resetPinN);
    assign ckiRise = clockInputPin & ~ckiPrev_q;
    assign t0Overflow = (t0Cnt_q == 13'h1fff);
    // A write lands exactly once, in the cycle its response is raised, after both halves were taken.
    assign wrAddr = awAddr_q;
    assign wrData = wData_q;
    assign wrLane0 = wStrb_q[0];
    assign wrFire = awHeld_q & wHeld_q & ~s_axi_bvalid;

    // AXI write channel: address and data may arrive in either order; response follows both.
    always @(posedge mclk) begin
        if (rst) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 4'h0;
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= ~awHeld_q & ~s_axi_bvalid;
            s_axi_wready <= ~wHeld_q & ~s_axi_bvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (awHeld_q & wHeld_q & ~s_axi_bvalid) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr_q[1:0] == 2'h0 && awAddr_q <= `RCP_ADDR_PMC) ? 2'h0 : 2'h2;
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI read channel; the mode register is write-only and reads as zero.
    always @(posedge mclk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr)
                    `RCP_ADDR_PMODE: s_axi_rdata <= 32'h0;
                    `RCP_ADDR_CFG: s_axi_rdata <= {30'h0, clockSel_q};
                    `RCP_ADDR_STAT: s_axi_rdata <= {27'h0, pmcPending_q, starting_q, state_q, oscEn_q};
                    `RCP_ADDR_PMC: s_axi_rdata <= {31'h0, pmcPending_q};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Power-mode sequencer. Mode writes land only in RUN after start-up; CFG and PMC writes land in any state; the core is stopped outside RUN.
    always @(posedge mclk) begin
        if (anyReset) begin
            state_q <= ST_RESET;
            startCnt_q <= 23'h0;
            starting_q <= 1'b1;
            haltReq_q <= 1'b0;
            idleReq_q <= 1'b0;
            pmcPending_q <= 1'b0;
            clockSel_q <= `RCP_CFG_RESET;
        end else begin
            if (wrFire && wrLane0 && wrAddr == `RCP_ADDR_CFG) begin
                clockSel_q <= wrData[`RCP_CSEL_MSB:`RCP_CSEL_LSB];
            end
            if (wrFire && wrLane0 && wrAddr == `RCP_ADDR_PMC) begin
                pmcPending_q <= 1'b0;
            end
            case (state_q)
                ST_RESET: begin
                    // Core held until the oscillator start-up time has elapsed.
                    if (startCnt_q >= STARTUP_LAST) begin
                        state_q <= ST_RUN;
                        starting_q <= 1'b0;
                    end else begin
                        startCnt_q <= startCnt_q + 23'h1;
                    end
                end
                ST_RUN: begin
                    if (starting_q) begin
                        if (startCnt_q >= STARTUP_LAST) begin
                            starting_q <= 1'b0;
                        end else begin
                            startCnt_q <= startCnt_q + 23'h1;
                        end
                    end else if (wrFire && wrLane0 && wrAddr == `RCP_ADDR_PMODE) begin
                        if (wrData[`RCP_HALT_BIT]) begin
                            state_q <= ST_HALT;
                            haltReq_q <= 1'b1;
                        end else if (wrData[`RCP_IDLE_BIT]) begin
                            state_q <= ST_IDLE;
                            idleReq_q <= 1'b1;
                        end
                    end
                end
                ST_HALT: begin
                    if (multiInputWakeup) begin
                        state_q <= ST_RUN;
                        haltReq_q <= 1'b0;
                        pmcPending_q <= 1'b1;
                        starting_q <= 1'b1;
                        startCnt_q <= 23'h0;
                    end
                end
                ST_IDLE: begin
                    if (multiInputWakeup | t0Overflow) begin
                        state_q <= ST_RUN;
                        idleReq_q <= 1'b0;
                        pmcPending_q <= 1'b1;
                    end
                end
                default: state_q <= ST_RESET;
            endcase
        end
    end

    // Timer 0 keeps counting in IDLE; it overflows once every 8192 cycles.
    always @(posedge mclk) begin
        if (anyReset || state_q == ST_HALT) begin
            t0Cnt_q <= 13'h0;
        end else begin
            t0Cnt_q <= t0Cnt_q + 13'h1;
        end
    end

    // Internal oscillator model: 2MHz tick from mclk, halved to 1MHz; external ticks divided.
    always @(posedge mclk) begin
        if (rst) begin
            oscCnt_q <= 5'h0;
            oscEn_q <= 1'b0;
            oscHalf_q <= 1'b0;
            extDiv_q <= 2'h0;
            ckiPrev_q <= 1'b0;
        end else begin
            ckiPrev_q <= clockInputPin;
            oscEn_q <= 1'b0;
            // The 2MHz tick only yields an instruction on every second tick.
            if (oscEn_q) begin
                oscHalf_q <= ~oscHalf_q;
            end
            if (oscRunQ) begin
                if (oscCnt_q == OSC_LAST) begin
                    oscCnt_q <= 5'h0;
                    oscEn_q <= 1'b1;
                end else begin
                    oscCnt_q <= oscCnt_q + 5'h1;
                end
            end
            if (ckiRise) begin
                extDiv_q <= extDiv_q + 2'h1;
            end
        end
    end

    // Registered outputs: clock enables, subsystem gates and the crystal drive pin.
    always @(posedge mclk) begin
        if (rst) begin
            coreResetQ <= 1'b1;
            ioResetQ <= 1'b1;
            instrClkEnQ <= 1'b0;
            oscRunQ <= 1'b1;
            detectorsEnQ <= 1'b0;
            timer0RunQ <= 1'b0;
            crystalOutQ <= 1'b0;
            crystalOutEnQ <= 1'b0;
        end else begin
            coreResetQ <= anyReset | (state_q == ST_RESET);
            ioResetQ <= anyReset | (state_q == ST_RESET);
            oscRunQ <= (state_q != ST_HALT) && (clockSel_q == `RCP_CSEL_INT);
            detectorsEnQ <= (state_q == ST_RUN);
            timer0RunQ <= (state_q == ST_RUN) || (state_q == ST_IDLE);
            crystalOutEnQ <= (clockSel_q == `RCP_CSEL_XTAL);
            crystalOutQ <= (clockSel_q == `RCP_CSEL_XTAL) & ~clockInputPin;
            if (state_q != ST_RUN || starting_q || anyReset) begin
                instrClkEnQ <= 1'b0;
            end else begin
                case (clockSel_q)
                    `RCP_CSEL_INT: instrClkEnQ <= oscEn_q & oscHalf_q;
                    `RCP_CSEL_SQ: instrClkEnQ <= ckiRise;
                    default: instrClkEnQ <= ckiRise & (extDiv_q == 2'h3);
                endcase
            end
        end
    end

endmodule // rcp_reset_clock_power

//--- tb/rcp_ext_partner.sv
// Model of the external reset circuit and the external clock source.
`timescale 1ns/1ps
module rcp_ext_partner #(
    parameter HOLD = 40
) (
    // Clock and press request from the bench.
    input logic mclk,
    input logic press,
    // Pins driven into the block.
    output logic resetPinN,
    output logic clockInputPin
);
    int holdCnt = 0;
    // A press keeps the pin low for the full hold time, so the clock can settle.
    always @(posedge mclk) begin
        if (press)
            holdCnt <= HOLD;
        else if (holdCnt != 0)
            holdCnt <= holdCnt - 1;
    end
    // A released pin floats to the pull-up level.
    assign resetPinN = (holdCnt == 0);
    // Free-running source at the top of its range, at a fixed phase offset from mclk.
    initial begin
        clockInputPin = 1'b0;
        #7;
        forever #125 clockInputPin = ~clockInputPin;
    end
endmodule // rcp_ext_partner

//--- tb/rcp_reset_clock_power_monitor.sv
// Concurrent checks on the ports of the reset, clock and power-mode block.
`timescale 1ns/1ps
module rcp_monitor #(
    parameter STARTUP_CYCLES = 20
) (
    // Clock, reset, reset sources and the wake source.
    input logic mclk,
    input logic rst,
    input logic powerOnDetect,
    input logic brownoutDetect,
    input logic watchdogExpire,
    input logic resetPinN,
    input logic resetPinPresent,
    input logic multiInputWakeup,
    // Bus handshakes.
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    // System outputs.
    input logic coreResetQ,
    input logic ioResetQ,
    input logic instrClkEnQ,
    input logic oscRunQ,
    input logic detectorsEnQ,
    input logic timer0RunQ
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    int quietCnt;
    wire srcOn = rst | powerOnDetect | brownoutDetect | watchdogExpire | (resetPinPresent & ~resetPinN);
    // Cycles since the last active reset source; saturates so it never wraps.
    always @(posedge mclk) begin
        if (srcOn)
            quietCnt <= 0;
        else if (quietCnt < 100000)
            quietCnt <= quietCnt + 1;
    end
    sequence s_halted; !oscRunQ && !timer0RunQ && !coreResetQ; endsequence
    sequence s_idling; oscRunQ && timer0RunQ && !detectorsEnQ && !coreResetQ; endsequence
    property p_src_reset; srcOn |=> coreResetQ; endproperty
    property p_io_reset; coreResetQ |-> ioResetQ; endproperty
    property p_no_exec; coreResetQ |-> !instrClkEnQ; endproperty
    property p_release; $fell(coreResetQ) |-> quietCnt >= STARTUP_CYCLES; endproperty
    property p_halt_hold; s_halted ##0 !multiInputWakeup ##0 !$past(multiInputWakeup) |=> !timer0RunQ; endproperty
    property p_halt_quiet; s_halted |-> !detectorsEnQ; endproperty
    property p_idle_wake; s_idling ##0 multiInputWakeup |-> ##2 detectorsEnQ; endproperty
    property p_run_timer; detectorsEnQ |-> timer0RunQ; endproperty
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_src_reset: assert property (p_src_reset) else $error("reset source missed");
    a_io_reset: assert property (p_io_reset) else $error("io not reset");
    a_no_exec: assert property (p_no_exec) else $error("clock during reset");
    a_release: assert property (p_release) else $error("early release");
    a_halt_hold: assert property (p_halt_hold) else $error("halt left without wake");
    a_halt_quiet: assert property (p_halt_quiet) else $error("detectors on in halt");
    a_idle_wake: assert property (p_idle_wake) else $error("idle wake late");
    a_run_timer: assert property (p_run_timer) else $error("timer stopped in run");
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
endmodule // rcp_monitor
bind rcp_reset_clock_power rcp_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES)) rcp_monitor_i (.*);

//--- tb/rcp_reset_clock_power_tb.sv
// Self-checking bench of the reset, clock and power-mode block.
`timescale 1ns/1ps
`include "rcp_regs.vh"
module rcp_reset_clock_power_tb;
    localparam int SU = 20;
    logic mclk, rst, powerOnDetect, brownoutDetect, watchdogExpire, resetPinPresent, multiInputWakeup, press;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, resetPinN, clockInputPin;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire coreResetQ, ioResetQ, instrClkEnQ, oscRunQ, detectorsEnQ, timer0RunQ, crystalOutQ, crystalOutEnQ;
    int err_count = 0;
    int comparisons = 0;
    int n, k, x;
    logic ck;
    logic [31:0] rd;
    logic [1:0] rs;
    // Rows: source code, crystal drive, oscillator running, instruction pulses in 400 cycles.
    int rows [4][4] = '{'{0, 0, 1, 10}, '{1, 0, 0, 40}, '{2, 1, 0, 10}, '{3, 0, 0, 10}};
    rcp_reset_clock_power #(.STARTUP_CYCLES(SU)) rcp_reset_clock_power_i (.*);
    rcp_ext_partner #(.HOLD(40)) rcp_ext_partner_i (.mclk(mclk), .press(press), .resetPinN(resetPinN),
        .clockInputPin(clockInputPin));
    // Main clock.
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task close_out;
        $display("Counts: comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task lost(input string m);
        err_count++;
        $display("MISMATCH %0t %s timed out", $time, m);
        close_out;
    endtask
    // Bus write; the leading edge keeps back-to-back calls off the same time step.
    task axw(input logic [3:0] a, input logic [31:0] d);
        logic done;
        done = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (n = 0; n < 50 && !done; n++) begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) begin
                done = 1;
                rs = s_axi_bresp;
                s_axi_bready <= 0;
            end
        end
        if (!done) lost("write");
    endtask
    task axr(input logic [3:0] a);
        logic done;
        done = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (n = 0; n < 50 && !done; n++) begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) begin
                done = 1;
                rd = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 0;
            end
        end
        if (!done) lost("read");
    endtask
    // Detectors run in RUN, so they mark the end of the reset start-up but not of the HALT wake-up delay.
    task waitRun;
        for (n = 0; n < 9000 && detectorsEnQ !== 1'b1; n++) @(posedge mclk);
        if (n == 9000) lost("run");
    endtask
    // The first instruction pulse marks the end of a wake-up delay.
    task waitClk;
        for (n = 0; n < 9000 && instrClkEnQ !== 1'b1; n++) @(posedge mclk);
        if (n == 9000) lost("clock");
    endtask
    initial begin
        {rst, press, resetPinPresent} = 3'h5;
        {powerOnDetect, brownoutDetect, watchdogExpire, multiInputWakeup} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 32'h0, 4'h1};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        repeat (4) @(posedge mclk);
        chk(ioResetQ, 1, "io reset");
        rst <= 0;
        waitRun;
        chk(n >= SU, 1, "start-up");
        for (int i = 0; i < 4; i++) begin
            axw(`RCP_ADDR_CFG, rows[i][0]);
            chk(rs, 2'h0, "write resp");
            repeat (20) @(posedge mclk);
            chk(crystalOutEnQ, rows[i][1], "crystal drive");
            chk(oscRunQ, rows[i][2], "oscillator");
            k = 0;
            x = 0;
            ck = clockInputPin;
            // The crystal drive follows the inverted input pin one cycle later.
            repeat (400) begin
                @(posedge mclk);
                k += instrClkEnQ;
                x += (crystalOutQ !== (rows[i][1] == 1 && ck == 1'b0));
                ck = clockInputPin;
            end
            chk(k >= rows[i][3] - 1 && k <= rows[i][3] + 1, 1, "instr rate");
            chk(x, 0, "crystal output");
            axr(`RCP_ADDR_CFG);
            chk(rd[1:0], rows[i][0], "cfg read");
        end
        // Each source held past the start-up delay; the pin is pressed through the partner.
        for (int s = 0; s < 4; s++) begin
            {press, watchdogExpire, brownoutDetect, powerOnDetect} <= 4'h1 << s;
            @(posedge mclk);
            press <= 0;
            repeat (30) @(posedge mclk);
            chk(coreResetQ, 1, "held in reset");
            {watchdogExpire, brownoutDetect, powerOnDetect} <= 3'h0;
            waitRun;
            chk(n >= SU, 1, "release");
        end
        axr(`RCP_ADDR_CFG);
        chk(rd, 0, "cfg reset value");
        resetPinPresent <= 0;
        press <= 1;
        @(posedge mclk);
        press <= 0;
        repeat (45) @(posedge mclk);
        chk(coreResetQ, 0, "absent pin");
        resetPinPresent <= 1;
        // HALT, IDLE and both bits at once, each ended by a wakeup pulse.
        for (int m = 1; m < 4; m++) begin
            axw(`RCP_ADDR_PMODE, m);
            repeat (30) @(posedge mclk);
            chk({oscRunQ, timer0RunQ, detectorsEnQ}, m == 2 ? 3'b110 : 3'b000, "mode");
            multiInputWakeup <= 1;
            @(posedge mclk);
            multiInputWakeup <= 0;
            // IDLE resumes at once; HALT keeps the instruction clock off for the start-up delay.
            if (m == 2) begin
                waitRun;
                chk(n <= 2, 1, "idle wake delay");
            end else begin
                waitClk;
                chk(n >= SU, 1, "halt wake delay");
            end
            axr(`RCP_ADDR_PMC);
            chk(rd, 1, "wake flag");
            axw(`RCP_ADDR_PMC, 1);
            axr(`RCP_ADDR_PMC);
            chk(rd, 0, "wake flag cleared");
        end
        axr(`RCP_ADDR_PMODE);
        chk(rd, 0, "write-only read");
        axr(4'h2);
        chk(rs, 2'h2, "unmapped");
        axw(4'h2, 1);
        chk(rs, 2'h2, "unmapped write");
        axw(`RCP_ADDR_PMODE, 2);
        repeat (3) @(posedge mclk);
        chk(detectorsEnQ, 0, "idle entered");
        waitRun;
        chk(n <= `RCP_T0_PERIOD, 1, "timer wake");
        close_out;
    end
endmodule // rcp_reset_clock_power_tb
